// >>> design/sasr_top.sv
// Conversion sequencer and serial read-out of a 12-bit SAR converter.
// Assumes frame select and shift clock arrive as pins from the host and
// the comparator output arrives asynchronously from the analogue core.
`timescale 1ns/100ps
module sasr_top
  import sasr_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic frame_sel_n,
  input wire logic shift_clk,
  input wire logic cmp_above,
  output logic serial_result_out,
  output logic serial_result_oe,
  output logic hold_active,
  output logic [RES_BITS-1:0] dac_code,
  output logic result_valid,
  input wire logic result_ready,
  output logic [RES_BITS-1:0] result_data,
  output logic capture_ready
);
  // Pin synchronisers
  logic fs_s1_r;
  logic fs_s2_r;
  logic fs_d_r;
  logic sck_s1_r;
  logic sck_s2_r;
  logic sck_d_r;
  logic cmp_s1_r;
  logic cmp_s2_r;

  sasr_state_type state_r;
  sasr_state_type state_nxt;
  logic [CNT_BITS-1:0] rise_cnt_r;
  logic [CNT_BITS-1:0] fall_cnt_r;
  logic [RES_BITS-1:0] sar_r;
  logic [RES_BITS-1:0] dac_r;
  logic out_r;
  logic oe_r;
  logic push_r;
  logic hold_r;

  wire frame_fall = fs_d_r & ~fs_s2_r;
  wire frame_on = ~fs_s2_r;
  // A shift edge seen together with the frame start is not counted, so
  // the read-out cannot slip a bit when both pins move at once
  wire edge_ok = frame_on & ~frame_fall;
  wire sck_rise = edge_ok & ~sck_d_r & sck_s2_r;
  wire sck_fall = edge_ok & sck_d_r & ~sck_s2_r;
  wire [CNT_BITS-1:0] rise_inc =
    (rise_cnt_r == CNT_MAX) ? rise_cnt_r : rise_cnt_r + 5'h01;
  wire [CNT_BITS-1:0] fall_inc =
    (fall_cnt_r == CNT_MAX) ? fall_cnt_r : fall_cnt_r + 5'h01;
  wire track_edge = sck_rise && (rise_inc == RISE_TRACK);

  // Bit under trial on rise r is 12 - r
  wire [3:0] trial_pos = 4'(RISE_LAST_BIT - rise_inc);
  wire resolving = (state_r == ST_HOLD) && (rise_inc <= RISE_LAST_BIT);
  // One-hot masks for the bit under trial and the one after it
  logic [RES_BITS-1:0] trial_mask;
  logic [RES_BITS-1:0] next_mask;
  for (genvar b = 0; b < RES_BITS; b++) begin : g_mask
    assign trial_mask[b] = (trial_pos == 4'(b));
    assign next_mask[b] = (trial_pos == 4'(b + 1));
  end
  // Keep the trial bit when the input is above the trial level
  wire [RES_BITS-1:0] sar_dec =
    cmp_s2_r ? dac_r : (dac_r & ~trial_mask);
  wire [RES_BITS-1:0] dac_dec = sar_dec | next_mask;

  // Result bit for the falling edge just counted
  wire [3:0] out_idx = 4'(FALL_LAST_BIT - fall_inc);
  wire in_data_window =
    (fall_inc >= FALL_FIRST_BIT) && (fall_inc <= FALL_LAST_BIT);
  wire out_bit = in_data_window ? sar_r[out_idx] : 1'b0;

  // Outputs straight from flip-flops
  assign serial_result_out = out_r;
  assign serial_result_oe = oe_r;
  assign hold_active = hold_r;
  assign dac_code = dac_r;

  // Hold from frame start until rise thirteen or deselect
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_TRACK: begin
        if (frame_fall) begin
          state_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (track_edge) begin
          state_nxt = ST_TRACK;
        end else if (!frame_on) begin
          state_nxt = ST_TRACK;
        end
      end
      default: begin
        state_nxt = ST_TRACK;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      fs_s1_r <= 1'b1;
      fs_s2_r <= 1'b1;
      fs_d_r <= 1'b1;
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_d_r <= 1'b0;
      cmp_s1_r <= 1'b0;
      cmp_s2_r <= 1'b0;
    end else begin
      fs_s1_r <= frame_sel_n;
      fs_s2_r <= fs_s1_r;
      fs_d_r <= fs_s2_r;
      sck_s1_r <= shift_clk;
      sck_s2_r <= sck_s1_r;
      sck_d_r <= sck_s2_r;
      cmp_s1_r <= cmp_above;
      cmp_s2_r <= cmp_s1_r;
    end
  end

  // Edge numbering relative to the latest frame start
  always_ff @(posedge clock) begin
    if (srst || !frame_on) begin
      rise_cnt_r <= 5'h00;
      fall_cnt_r <= 5'h00;
    end else begin
      if (sck_rise) begin
        rise_cnt_r <= rise_inc;
      end
      if (sck_fall) begin
        fall_cnt_r <= fall_inc;
      end
    end
  end

  // Track and hold state; the hold output is its own flip-flop
  always_ff @(posedge clock) begin
    if (srst) begin
      state_r <= ST_TRACK;
      hold_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      hold_r <= (state_nxt == ST_HOLD);
    end
  end

  // Successive approximation, one bit per rising edge
  always_ff @(posedge clock) begin
    if (srst) begin
      sar_r <= RES_ZERO;
      dac_r <= DAC_MID;
      push_r <= 1'b0;
    end else begin
      push_r <= (state_r == ST_HOLD) && track_edge;
      if (frame_fall) begin
        sar_r <= RES_ZERO;
        dac_r <= DAC_MID;
      end else if (sck_rise && resolving) begin
        sar_r <= sar_dec;
        dac_r <= dac_dec;
      end
    end
  end

  // Serial output launched on falling shift-clock edges
  always_ff @(posedge clock) begin
    if (srst) begin
      out_r <= 1'b0;
      oe_r <= 1'b0;
    end else if (frame_fall) begin
      out_r <= 1'b0;
      oe_r <= 1'b1;
    end else if (!frame_on) begin
      out_r <= 1'b0;
      oe_r <= 1'b0;
    end else if (sck_fall) begin
      if (fall_inc >= FALL_RELEASE) begin
        out_r <= 1'b0;
        oe_r <= 1'b0;
      end else begin
        out_r <= out_bit;
      end
    end
  end

  // Finished words wait here for the consumer
  sasr_buffer u_buffer (
    .clock(clock),
    .srst(srst),
    .in_valid(push_r),
    .in_ready(capture_ready),
    .in_data(sar_r),
    .out_valid(result_valid),
    .out_ready(result_ready),
    .out_data(result_data)
  );
endmodule

// >>> design/sasr_pkg.sv
// Package for the converter sequencer and serial read-out.
// Assumes a single 100 MHz system clock; no software registers.
package sasr_pkg;
  localparam int RES_BITS = 12;
  localparam int CNT_BITS = 5;
  localparam logic [CNT_BITS-1:0] CNT_MAX = 5'h1F;
  // Rising edge on which the converter returns to track
  localparam logic [CNT_BITS-1:0] RISE_TRACK = 5'h0D;
  // Last rising edge that resolves a result bit
  localparam logic [CNT_BITS-1:0] RISE_LAST_BIT = 5'h0C;
  // Falling edge that returns the output to high impedance
  localparam logic [CNT_BITS-1:0] FALL_RELEASE = 5'h10;
  // First and last falling edge carrying a result bit
  localparam logic [CNT_BITS-1:0] FALL_FIRST_BIT = 5'h03;
  localparam logic [CNT_BITS-1:0] FALL_LAST_BIT = 5'h0E;
  localparam logic [RES_BITS-1:0] DAC_MID = 12'h800;
  localparam logic [RES_BITS-1:0] RES_ZERO = 12'h000;
  localparam int BUF_DEPTH = 2;
  typedef enum logic [1:0] {
    ST_TRACK = 2'b01,
    ST_HOLD = 2'b10
  } sasr_state_type;
endpackage

// >>> design/sasr_buffer.sv
// Two-entry word buffer with valid and ready on both sides.
// Assumes producer and consumer on the same clock as the buffer.
`timescale 1ns/100ps
module sasr_buffer
  import sasr_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [RES_BITS-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [RES_BITS-1:0] out_data
);
  logic [RES_BITS-1:0] mem_r [BUF_DEPTH];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic [1:0] count_r;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire [1:0] count_nxt = count_r + {1'b0, push} - {1'b0, pop};

  // Full and empty come straight from the count
  assign in_ready = (count_r != 2'h2);
  assign out_valid = (count_r != 2'h0);
  assign out_data = mem_r[rd_ptr_r];

  always_ff @(posedge clock) begin
    if (srst) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      count_r <= count_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end
endmodule

// >>> verif/sasr_props.sv
// Checker for frame timing of the serial read-out.
// Assumes pins are sampled on the system clock; bound into sasr_top.
`timescale 1ns/100ps
module sasr_props
  import sasr_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic frame_sel_n,
  input wire logic shift_clk,
  input wire logic serial_result_out,
  input wire logic serial_result_oe,
  input wire logic hold_active
);
  logic sh_r;
  logic [4:0] rise_r;
  logic [4:0] fall_r;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // Shift edges counted since frame start
  always_ff @(posedge clock) begin
    sh_r <= shift_clk;
    if (srst || frame_sel_n) begin
      rise_r <= 5'h00;
      fall_r <= 5'h00;
    end else begin
      rise_r <= rise_r + {4'h0, shift_clk & ~sh_r};
      fall_r <= fall_r + {4'h0, sh_r & ~shift_clk};
    end
  end
  start_hold_a: assert property (
    $fell(frame_sel_n) |-> ##[2:5] (serial_result_oe && hold_active
    && !serial_result_out)) else $error("frame start late");
  desel_off_a: assert property (
    $rose(frame_sel_n) |-> ##[2:5] !serial_result_oe)
    else $error("kept after deselect");
  idle_off_a: assert property (
    frame_sel_n [*6] |-> !serial_result_oe) else $error("driving idle");
  launch_fall_a: assert property (
    $changed(serial_result_out) |-> !shift_clk) else $error("bad launch");
  track_13_a: assert property (
    $fell(hold_active) && !frame_sel_n |-> rise_r == 5'h0D)
    else $error("track edge wrong");
  hold_early_a: assert property (
    !frame_sel_n && rise_r inside {[5'h01:5'h0C]} |-> hold_active)
    else $error("left hold early");
  release_16_a: assert property (
    fall_r == 5'h10 |-> ##[2:5] !serial_result_oe) else $error("no release");
  drive_15_a: assert property (
    !frame_sel_n && fall_r inside {[5'h01:5'h0F]} |-> serial_result_oe)
    else $error("output dropped");
  track_resume_a: assert property (
    !frame_sel_n && rise_r == 5'h0D |-> ##[2:5] !hold_active)
    else $error("hold kept after edge 13");
endmodule
bind sasr_top sasr_props u_props (.*);

// >>> verif/sasr_host.sv
// Host model: frame select, shift clock, bit capture.
// Assumes the system clock paces its timing.
`timescale 1ns/100ps
module sasr_host (
  input wire logic clock,
  input wire logic sdo,
  input wire logic sdo_oe,
  output logic frame_sel_n = 1'b1,
  output logic shift_clk = 1'b0
);
  task automatic half();
    repeat (8) @(posedge clock);
    #1;
  endtask
  // Frame of n shift cycles; a released line reads high
  task automatic frame(input int n, output logic [15:0] word);
    word = 16'h0000;
    frame_sel_n = 1'b0;
    half();
    for (int i = 0; i < n; i++) begin
      shift_clk = 1'b1;
      word = {word[14:0], sdo_oe ? sdo : 1'b1};
      half();
      shift_clk = 1'b0;
      half();
    end
    frame_sel_n = 1'b1;
    repeat (4) half();
  endtask
endmodule

// >>> verif/testbench.sv
// Testbench: host frames, comparator model, result drain.
// Assumes sasr_top, sasr_host and the checker are compiled first.
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
  $display("BAD at %0t got %h exp %h", $time, a, b); end end
module testbench;
  import sasr_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic result_ready = 1'b0;
  logic [RES_BITS-1:0] target = RES_ZERO;
  logic [15:0] word;
  int bad_count = 0;
  int n_tests = 0;
  wire logic fsel_n, sclk, cmp, sdo, soe, hold, r_valid, c_ready;
  wire logic [RES_BITS-1:0] dac, r_data;
  always #5 clock = ~clock;
  // Input sits half a step above target
  assign cmp = (dac <= target) === 1'b1;
  sasr_top dut (.clock(clock), .srst(srst), .frame_sel_n(fsel_n),
    .shift_clk(sclk), .cmp_above(cmp), .serial_result_out(sdo),
    .serial_result_oe(soe), .hold_active(hold), .dac_code(dac),
    .result_valid(r_valid), .result_ready(result_ready),
    .result_data(r_data), .capture_ready(c_ready));
  sasr_host host (.clock(clock), .sdo(sdo), .sdo_oe(soe),
    .frame_sel_n(fsel_n), .shift_clk(sclk));
  task automatic t_frames();
    logic [RES_BITS-1:0] v [3] = '{12'hA5C, 12'hFFF, RES_ZERO};
    for (int i = 0; i < 3; i++) begin
      target = v[i];
      host.frame(16, word);
      `CHK(word, {3'b000, v[i], 1'b0})
    end
    `CHK(c_ready, 1'b0)
    for (int i = 0; i < 2; i++) begin
      `CHK(r_data, v[i])
      result_ready = 1'b1;
      @(posedge clock);
      #1;
      result_ready = 1'b0;
    end
    `CHK(r_valid, 1'b0)
    $display("t_frames done");
  endtask
  task automatic t_abort();
    target = 12'h123;
    host.frame(5, word);
    `CHK(soe, 1'b0)
    `CHK(r_valid, 1'b0)
    host.frame(16, word);
    `CHK(word, {3'b000, target, 1'b0})
    `CHK(r_valid, 1'b1)
    `CHK(r_data, target)
    $display("t_abort done");
  endtask
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clock);
    #1;
    srst = 1'b0;
    t_frames();
    t_abort();
    give_verdict();
  end
endmodule
